/* tsc_consts.vh */
// Constants for the touch scan configuration and tracking block:
// register offsets, field positions, reset values and timing figures.
// Assumes it is included by bare name from the design files.
`ifndef TSC_CONSTS_VH
`define TSC_CONSTS_VH

// Register offsets
`define TSC_ADDR_NOISE_OFFSET 8'h07
`define TSC_ADDR_TIMING 8'h08
`define TSC_ADDR_DEBOUNCE 8'h09
`define TSC_ADDR_TRACKING 8'h0A
`define TSC_ADDR_DOWN_LIMIT 8'h0B
`define TSC_ADDR_IRQ_ENABLE 8'h0D
`define TSC_ADDR_RAW_HI 8'h20
`define TSC_ADDR_RAW_LO 8'h21
`define TSC_ADDR_SMOOTH_HI 8'h22
`define TSC_ADDR_SMOOTH_LO 8'h23
`define TSC_ADDR_CHANGE_HI 8'h24
`define TSC_ADDR_CHANGE_LO 8'h25
`define TSC_ADDR_REF_HI 8'h26
`define TSC_ADDR_REF_LO 8'h27
`define TSC_ADDR_SMOOTHING 8'h2B
`define TSC_ADDR_FLAG 8'h2D

// Reset values
`define TSC_RST_NOISE_OFFSET 8'h00
`define TSC_RST_TIMING 8'h02
`define TSC_RST_DEBOUNCE 8'h50
`define TSC_RST_TRACKING 8'h33
`define TSC_RST_DOWN_LIMIT 8'h08
`define TSC_RST_IRQ_ENABLE 8'h00
`define TSC_RST_SMOOTHING 8'h4C

// Field positions
`define TSC_NOISE_SEL_HI 7
`define TSC_NOISE_SEL_LO 6
`define TSC_COMP_HI 4
`define TSC_COMP_LO 0
`define TSC_MOT_HI 7
`define TSC_MOT_LO 6
`define TSC_IDLE_IN_HI 5
`define TSC_IDLE_IN_LO 4
`define TSC_WAIT_HI 2
`define TSC_WAIT_LO 0
`define TSC_DEB_HI 3
`define TSC_DEB_LO 2
`define TSC_UP_HI 6
`define TSC_UP_LO 4
`define TSC_DN_HI 2
`define TSC_DN_LO 0
`define TSC_IRQ_EN_BIT 3
`define TSC_COEF_HI 3
`define TSC_COEF_LO 2
`define TSC_FLAG_BIT 0

// Frame counts for the on-time and idle-entry limits
`define TSC_MOT_LIM1 12'd600
`define TSC_MOT_LIM2 12'd2000
`define TSC_MOT_LIM3 12'd100
`define TSC_IDLE_LIM1 12'd64
`define TSC_IDLE_LIM2 12'd256
`define TSC_IDLE_LIM3 12'd1024

// Timing
`define TSC_CLK_MHZ 200
`define TSC_CARRIER_US 2
`define TSC_CARRIER_CYC (`TSC_CARRIER_US * `TSC_CLK_MHZ)
`define TSC_FRAME_UNITS 4096
`define TSC_IDLE_STEP_MS 16
`define TSC_IDLE_STEP_CYC (`TSC_IDLE_STEP_MS * 1000 * `TSC_CLK_MHZ)
`define TSC_OFF_CONSEC 4'd2

`endif

/* tsc_frame_timer.v */
// Frame period timer: a one-cycle pulse every 2 us x (carrier count + 1) x 4096.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
`include "tsc_consts.vh"

module tsc_frame_timer #(
	parameter integer CARRIER_CYC = `TSC_CARRIER_CYC
) (
	input wire core_clk,
	input wire sys_rst,
	input wire [3:0] carrier_count,
	output reg frame_tick
);

	reg [15:0] pre_cnt_reg;
	reg [16:0] unit_cnt_reg;
	wire [4:0] car_plus = {1'b0, carrier_count} + 5'h01;
	wire [16:0] unit_end = {car_plus, 12'h000} - 17'h00001;
	wire unit_tick = (pre_cnt_reg == CARRIER_CYC[15:0] - 16'h0001);

	// Carrier prescaler, then frame counter in carrier units
	always @(posedge core_clk) begin
		if (sys_rst) begin
			pre_cnt_reg <= 16'h0000;
			unit_cnt_reg <= 17'h00000;
			frame_tick <= 1'b0;
		end else begin
			frame_tick <= 1'b0;
			if (unit_tick) begin
				pre_cnt_reg <= 16'h0000;
				// Compare with >= so a lowered carrier count cannot strand the counter
				if (unit_cnt_reg >= unit_end) begin
					unit_cnt_reg <= 17'h00000;
					frame_tick <= 1'b1;
				end else begin
					unit_cnt_reg <= unit_cnt_reg + 17'h00001;
				end
			end else begin
				pre_cnt_reg <= pre_cnt_reg + 16'h0001;
			end
		end
	end

endmodule // tsc_frame_timer
`default_nettype wire

/* tsc_top.v */
// Touch scan configuration, tracking and readout for one capacitive channel.
// Assumes an outer serial slave presents byte reads and writes on the register port,
// and the converter delivers one 16-bit result per cycle-wide valid pulse.
//
// Overview of operation
// - Two-bit noise filter select, zero is off
// - Five-bit compensation code drives analog cancellation
// - On-time limit reinitialises baseline: off, 600, 2000
// - On-time code three limits to 100 frames
// - Frame is 2us x (carriers+1) x 4096
// - Off-time limit enters idle: never, 64, 256, 1024
// - Idle inserts wait of code x 16 ms
// - Touch on after N consecutive deltas above threshold
// - Baseline up one after 2x up-rate samples
// - Baseline down one after 2x down-rate samples
// - Down limit re-establishes baseline on large drop
// - Enable bit three gates scan boundary interrupt
// - Flag set per result, cleared by read
// - Raw, smoothed, change, baseline readable as byte pairs
// - Smoothing coefficient quarter, eighth, half, bypass
// - Status bit shows touch on
`timescale 1ns/1ps
`default_nettype none
`include "tsc_consts.vh"

module tsc_top #(
	parameter integer CARRIER_CYC = `TSC_CARRIER_CYC,
	parameter integer IDLE_STEP_CYC = `TSC_IDLE_STEP_CYC
) (
	input wire core_clk,
	input wire sys_rst,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	input wire cdc_valid,
	input wire [15:0] cdc_data,
	input wire [3:0] carrier_count,
	input wire [7:0] touch_on_limit,
	input wire [7:0] touch_off_limit,
	output reg cdc_run,
	output reg [1:0] radio_noise_filter_sel,
	output reg [4:0] comp_code,
	output reg touch_state_bit,
	output reg idle_state,
	output reg irq_n_o,
	output reg irq_n_oe
);

	// Software-visible configuration and status
	reg [7:0] noise_offset_reg;
	reg [7:0] timing_reg;
	reg [7:0] debounce_reg;
	reg [7:0] tracking_reg;
	reg [7:0] down_limit_reg;
	reg [7:0] irq_enable_reg;
	reg [7:0] smoothing_reg;
	reg flag_reg;
	// Data path
	reg [15:0] raw_reg;
	reg [15:0] smooth_reg;
	reg [15:0] change_reg;
	reg [15:0] base_reg;
	reg primed_reg;
	// Detection and tracking counters
	reg [3:0] deb_cnt_reg;
	reg [3:0] off_cnt_reg;
	reg [3:0] up_cnt_reg;
	reg [3:0] dn_cnt_reg;
	reg [3:0] drop_cnt_reg;
	reg [11:0] frame_cnt_reg;
	reg [24:0] wait_cnt_reg;
	reg touch_reg;
	reg idle_reg;
	reg run_reg;

	wire frame_tick;

	tsc_frame_timer #(
		.CARRIER_CYC(CARRIER_CYC)
	) u_frame (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.carrier_count(carrier_count),
		.frame_tick(frame_tick)
	);

	// Field views
	wire [1:0] mot_code = timing_reg[`TSC_MOT_HI:`TSC_MOT_LO];
	wire [1:0] idle_code = timing_reg[`TSC_IDLE_IN_HI:`TSC_IDLE_IN_LO];
	wire [2:0] wait_code = timing_reg[`TSC_WAIT_HI:`TSC_WAIT_LO];
	wire [1:0] deb_code = debounce_reg[`TSC_DEB_HI:`TSC_DEB_LO];
	wire [2:0] up_rate = tracking_reg[`TSC_UP_HI:`TSC_UP_LO];
	wire [2:0] dn_rate = tracking_reg[`TSC_DN_HI:`TSC_DN_LO];
	wire [1:0] coef = smoothing_reg[`TSC_COEF_HI:`TSC_COEF_LO];
	wire irq_en = irq_enable_reg[`TSC_IRQ_EN_BIT];

	// Smoothing: new = old + (raw - old) / 2^k, bypass loads raw
	reg [1:0] shift_k;
	always @* begin
		case (coef)
			2'b00: shift_k = 2'd2;
			2'b01: shift_k = 2'd3;
			2'b10: shift_k = 2'd1;
			default: shift_k = 2'd0;
		endcase
	end
	wire signed [16:0] sm_diff = $signed({1'b0, cdc_data}) - $signed({1'b0, smooth_reg});
	wire signed [16:0] sm_step = sm_diff >>> shift_k;
	wire [15:0] sm_filt = smooth_reg + sm_step[15:0];
	wire [15:0] smooth_new = (!primed_reg || coef == 2'b11) ? cdc_data : sm_filt;

	// Change from baseline, compared against four times the touch thresholds and against the down limit unscaled
	wire signed [16:0] delta_new = $signed({1'b0, smooth_new}) - $signed({1'b0, base_reg});
	wire signed [16:0] on_thr = $signed({7'h00, touch_on_limit, 2'b00});
	wire signed [16:0] off_thr = $signed({7'h00, touch_off_limit, 2'b00});
	wire signed [16:0] drop_thr = $signed({9'h000, down_limit_reg});
	wire above_on = delta_new > on_thr;
	wire below_off = delta_new < off_thr;
	wire above_base = smooth_new > base_reg;
	wire below_base = smooth_new < base_reg;
	wire big_drop = (-delta_new) > drop_thr;
	wire [3:0] deb_need = {1'b0, deb_code, 1'b0} + 4'h2;
	wire [3:0] up_need = {up_rate, 1'b0};
	wire [3:0] dn_need = {dn_rate, 1'b0};

	// Frame limits for on-time and idle entry
	reg [11:0] mot_lim;
	reg [11:0] idle_lim;
	always @* begin
		case (mot_code)
			2'b01: mot_lim = `TSC_MOT_LIM1;
			2'b10: mot_lim = `TSC_MOT_LIM2;
			2'b11: mot_lim = `TSC_MOT_LIM3;
			default: mot_lim = 12'h000;
		endcase
		case (idle_code)
			2'b01: idle_lim = `TSC_IDLE_LIM1;
			2'b10: idle_lim = `TSC_IDLE_LIM2;
			2'b11: idle_lim = `TSC_IDLE_LIM3;
			default: idle_lim = 12'h000;
		endcase
	end
	wire mot_expire = touch_reg && mot_lim != 12'h000 && frame_cnt_reg >= mot_lim;
	wire idle_enter = !touch_reg && !idle_reg && idle_lim != 12'h000 && frame_cnt_reg >= idle_lim;

	// Idle wait length; width covers 112 ms at the default step
	wire [31:0] wait_prod = wait_code * IDLE_STEP_CYC;
	wire [24:0] wait_load = wait_prod[24:0];

	// Register writes; hardware set of the flag wins over a clearing read
	always @(posedge core_clk) begin
		if (sys_rst) begin
			noise_offset_reg <= `TSC_RST_NOISE_OFFSET;
			timing_reg <= `TSC_RST_TIMING;
			debounce_reg <= `TSC_RST_DEBOUNCE;
			tracking_reg <= `TSC_RST_TRACKING;
			down_limit_reg <= `TSC_RST_DOWN_LIMIT;
			irq_enable_reg <= `TSC_RST_IRQ_ENABLE;
			smoothing_reg <= `TSC_RST_SMOOTHING;
			flag_reg <= 1'b0;
		end else begin
			if (reg_wr) begin
				case (reg_addr)
					`TSC_ADDR_NOISE_OFFSET: noise_offset_reg <= reg_wdata;
					`TSC_ADDR_TIMING: timing_reg <= reg_wdata;
					`TSC_ADDR_DEBOUNCE: debounce_reg <= reg_wdata;
					`TSC_ADDR_TRACKING: tracking_reg <= reg_wdata;
					`TSC_ADDR_DOWN_LIMIT: down_limit_reg <= reg_wdata;
					`TSC_ADDR_IRQ_ENABLE: irq_enable_reg <= reg_wdata;
					`TSC_ADDR_SMOOTHING: smoothing_reg <= reg_wdata;
					default: ;
				endcase
			end
			if (cdc_valid)
				flag_reg <= 1'b1;
			else if (reg_rd && reg_addr == `TSC_ADDR_FLAG)
				flag_reg <= 1'b0;
		end
	end

	// Read mux, registered; unmapped offsets read zero
	always @(posedge core_clk) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`TSC_ADDR_NOISE_OFFSET: reg_rdata <= noise_offset_reg;
				`TSC_ADDR_TIMING: reg_rdata <= timing_reg;
				`TSC_ADDR_DEBOUNCE: reg_rdata <= debounce_reg;
				`TSC_ADDR_TRACKING: reg_rdata <= tracking_reg;
				`TSC_ADDR_DOWN_LIMIT: reg_rdata <= down_limit_reg;
				`TSC_ADDR_IRQ_ENABLE: reg_rdata <= irq_enable_reg;
				`TSC_ADDR_RAW_HI: reg_rdata <= raw_reg[15:8];
				`TSC_ADDR_RAW_LO: reg_rdata <= raw_reg[7:0];
				`TSC_ADDR_SMOOTH_HI: reg_rdata <= smooth_reg[15:8];
				`TSC_ADDR_SMOOTH_LO: reg_rdata <= smooth_reg[7:0];
				`TSC_ADDR_CHANGE_HI: reg_rdata <= change_reg[15:8];
				`TSC_ADDR_CHANGE_LO: reg_rdata <= change_reg[7:0];
				`TSC_ADDR_REF_HI: reg_rdata <= base_reg[15:8];
				`TSC_ADDR_REF_LO: reg_rdata <= base_reg[7:0];
				`TSC_ADDR_SMOOTHING: reg_rdata <= smoothing_reg;
				`TSC_ADDR_FLAG: reg_rdata <= {7'h00, flag_reg};
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	// Sample processing, touch decision and baseline tracking
	always @(posedge core_clk) begin
		if (sys_rst) begin
			raw_reg <= 16'h0000;
			smooth_reg <= 16'h0000;
			change_reg <= 16'h0000;
			base_reg <= 16'h0000;
			primed_reg <= 1'b0;
			deb_cnt_reg <= 4'h0;
			off_cnt_reg <= 4'h0;
			up_cnt_reg <= 4'h0;
			dn_cnt_reg <= 4'h0;
			drop_cnt_reg <= 4'h0;
			touch_reg <= 1'b0;
		end else if (mot_expire) begin
			// Stuck touch: restart detection from the present level
			base_reg <= smooth_reg;
			touch_reg <= 1'b0;
			deb_cnt_reg <= 4'h0;
			off_cnt_reg <= 4'h0;
			up_cnt_reg <= 4'h0;
			dn_cnt_reg <= 4'h0;
			drop_cnt_reg <= 4'h0;
		end else if (cdc_valid) begin
			raw_reg <= cdc_data;
			smooth_reg <= smooth_new;
			primed_reg <= 1'b1;
			if (!primed_reg) begin
				// First result seeds the baseline
				base_reg <= smooth_new;
				change_reg <= 16'h0000;
			end else begin
				change_reg <= delta_new[15:0];
				if (!touch_reg) begin
					// Debounce toward touch on
					if (above_on) begin
						if (deb_cnt_reg + 4'h1 >= deb_need) begin
							touch_reg <= 1'b1;
							deb_cnt_reg <= 4'h0;
						end else begin
							deb_cnt_reg <= deb_cnt_reg + 4'h1;
						end
					end else begin
						deb_cnt_reg <= 4'h0;
					end
					// Slow tracking; a zero rate leaves the baseline still
					if (above_base && up_need != 4'h0) begin
						dn_cnt_reg <= 4'h0;
						if (up_cnt_reg + 4'h1 >= up_need) begin
							base_reg <= base_reg + 16'h0001;
							up_cnt_reg <= 4'h0;
						end else begin
							up_cnt_reg <= up_cnt_reg + 4'h1;
						end
					end else if (below_base && dn_need != 4'h0) begin
						up_cnt_reg <= 4'h0;
						if (dn_cnt_reg + 4'h1 >= dn_need) begin
							base_reg <= base_reg - 16'h0001;
							dn_cnt_reg <= 4'h0;
						end else begin
							dn_cnt_reg <= dn_cnt_reg + 4'h1;
						end
					end else begin
						up_cnt_reg <= 4'h0;
						dn_cnt_reg <= 4'h0;
					end
					// Large sustained drop: jump the baseline instead of crawling
					if (big_drop) begin
						if (drop_cnt_reg + 4'h1 >= `TSC_OFF_CONSEC) begin
							base_reg <= smooth_new;
							drop_cnt_reg <= 4'h0;
						end else begin
							drop_cnt_reg <= drop_cnt_reg + 4'h1;
						end
					end else begin
						drop_cnt_reg <= 4'h0;
					end
				end else begin
					// Baseline frozen while touched; release after consecutive low deltas
					up_cnt_reg <= 4'h0;
					dn_cnt_reg <= 4'h0;
					drop_cnt_reg <= 4'h0;
					if (below_off) begin
						if (off_cnt_reg + 4'h1 >= `TSC_OFF_CONSEC) begin
							touch_reg <= 1'b0;
							off_cnt_reg <= 4'h0;
						end else begin
							off_cnt_reg <= off_cnt_reg + 4'h1;
						end
					end else begin
						off_cnt_reg <= 4'h0;
					end
				end
			end
		end
	end

	// Edge of touch state, for restarting the frame counter
	reg touch_prev_reg;
	wire touch_change = touch_prev_reg != touch_reg;

	// Frame counter for on-time and off-time limits
	always @(posedge core_clk) begin
		if (sys_rst) begin
			touch_prev_reg <= 1'b0;
			frame_cnt_reg <= 12'h000;
			idle_reg <= 1'b0;
		end else begin
			touch_prev_reg <= touch_reg;
			if (touch_change || mot_expire)
				frame_cnt_reg <= 12'h000;
			else if (frame_tick && frame_cnt_reg != 12'hFFF)
				frame_cnt_reg <= frame_cnt_reg + 12'h001;
			if (touch_reg)
				idle_reg <= 1'b0;
			else if (idle_enter)
				idle_reg <= 1'b1;
		end
	end

	// Idle pacing: pause the converter after each result while idle
	always @(posedge core_clk) begin
		if (sys_rst) begin
			wait_cnt_reg <= 25'h0000000;
			run_reg <= 1'b1;
		end else if (!idle_reg) begin
			// Back-to-back conversions outside idle
			wait_cnt_reg <= 25'h0000000;
			run_reg <= 1'b1;
		end else if (cdc_valid && wait_load != 25'h0000000) begin
			wait_cnt_reg <= wait_load - 25'h0000001;
			run_reg <= 1'b0;
		end else if (wait_cnt_reg != 25'h0000000) begin
			wait_cnt_reg <= wait_cnt_reg - 25'h0000001;
		end else begin
			run_reg <= 1'b1;
		end
	end

	// Output flops; the pin is open drain so only the enable moves
	always @(posedge core_clk) begin
		if (sys_rst) begin
			cdc_run <= 1'b1;
			radio_noise_filter_sel <= 2'b00;
			comp_code <= 5'h00;
			touch_state_bit <= 1'b0;
			idle_state <= 1'b0;
			irq_n_o <= 1'b0;
			irq_n_oe <= 1'b0;
		end else begin
			cdc_run <= run_reg;
			radio_noise_filter_sel <= noise_offset_reg[`TSC_NOISE_SEL_HI:`TSC_NOISE_SEL_LO];
			comp_code <= noise_offset_reg[`TSC_COMP_HI:`TSC_COMP_LO];
			touch_state_bit <= touch_reg;
			idle_state <= idle_reg;
			irq_n_o <= 1'b0;
			irq_n_oe <= flag_reg & irq_en;
		end
	end

endmodule // tsc_top
`default_nettype wire

/* tsc_host_model.sv */
// Host stand-in: byte-wide register master in place of the serial host.
// Assumes one clock; every request starts and ends on a rising edge.
`timescale 1ns/1ps
`default_nettype none
module tsc_host_model (
	input wire logic core_clk,
	input wire logic [7:0] reg_rdata,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd
);
	// Quiet bus before the first request
	initial begin
		reg_addr = 8'hFF;
		reg_wdata = 8'hA5;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// Released lines flip so stale values never look valid
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask

	// Data is taken one edge after the strobe is sampled
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		@(posedge core_clk);
		d = reg_rdata;
	endtask

	// Reserved upper bits carry their fixed pattern
	task automatic wr_deb(input logic [1:0] code);
		wr(8'h09, {4'h5, code, 2'b00});
	endtask

	task automatic wr_coef(input logic [1:0] code);
		wr(8'h2B, {4'b0100, code, 2'b00});
	endtask
endmodule // tsc_host_model
`default_nettype wire

/* tsc_top_props.sv */
// Checker for the touch scan block, watching only its top-level ports.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module tsc_top_chk (
	input wire core_clk,
	input wire sys_rst,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_rdata,
	input wire cdc_valid,
	input wire [15:0] cdc_data,
	input wire [1:0] radio_noise_filter_sel,
	input wire [4:0] comp_code,
	input wire touch_state_bit,
	input wire irq_n_o,
	input wire irq_n_oe
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);

	// Register lands on the write edge, output flop copies it one edge later
	a_sel_follows: assert property (reg_wr && reg_addr == 8'h07 |-> ##2 radio_noise_filter_sel == ($past(reg_wdata, 2) >> 6))
		else $error("noise select not taken from write");
	a_comp_follows: assert property (reg_wr && reg_addr == 8'h07 |-> ##2 comp_code == ($past(reg_wdata, 2) & 8'h1F))
		else $error("compensation code not taken from write");
	a_flag_read_one: assert property ((cdc_valid ##1 (!cdc_valid && !reg_rd)[*2] ##1 (reg_rd && reg_addr == 8'h2D)) |=> reg_rdata == 8'h01)
		else $error("flag not seen after result");
	a_flag_upper: assert property (reg_rd && reg_addr == 8'h2D |=> reg_rdata[7:1] == 7'h00)
		else $error("flag register upper bits set");
	a_raw_hi_read: assert property ((cdc_valid ##1 (!cdc_valid)[*2] ##1 (reg_rd && reg_addr == 8'h20 && !cdc_valid)) |=> reg_rdata == ($past(cdc_data, 4) >> 8))
		else $error("raw high byte wrong");
	a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without a read");
	a_touch_cause: assert property ($rose(touch_state_bit) |-> $past(cdc_valid, 2))
		else $error("touch rose without a result");
	a_irq_data_low: assert property (irq_n_o == 1'b0)
		else $error("interrupt data not low");
	a_irq_release: assert property ((reg_rd && reg_addr == 8'h2D && !cdc_valid) ##1 !cdc_valid |=> !irq_n_oe)
		else $error("interrupt kept after flag read");
endmodule // tsc_top_chk

bind tsc_top tsc_top_chk tsc_top_chk_i (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cdc_valid(cdc_valid),
	.cdc_data(cdc_data), .radio_noise_filter_sel(radio_noise_filter_sel), .comp_code(comp_code),
	.touch_state_bit(touch_state_bit), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe));
`default_nettype wire

/* tb_top.sv */
// Testbench for the touch scan block: registers, readout, flag, tracking, touch.
// Assumes the host model and checker are compiled first; frames are never waited out.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic cdc_valid = 1'b0;
	logic [15:0] cdc_data = 16'h0000;
	logic [7:0] on_lim = 8'h04;
	logic [7:0] off_lim = 8'h02;
	wire [7:0] reg_addr, reg_wdata, reg_rdata;
	wire reg_wr, reg_rd, touch, irq_o, irq_oe, run, idle;
	wire [1:0] sel;
	wire [4:0] comp;
	int num_errors = 0;
	int n_compared = 0;
	logic [7:0] rb;

	// Short carrier and idle steps keep the run small
	tsc_top #(.CARRIER_CYC(2), .IDLE_STEP_CYC(10)) tsc_top_i (.core_clk(core_clk), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.cdc_valid(cdc_valid), .cdc_data(cdc_data), .carrier_count(4'h0), .touch_on_limit(on_lim),
		.touch_off_limit(off_lim), .cdc_run(run), .radio_noise_filter_sel(sel), .comp_code(comp),
		.touch_state_bit(touch), .idle_state(idle), .irq_n_o(irq_o), .irq_n_oe(irq_oe));

	tsc_host_model host_i (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

	always #2.5 core_clk = ~core_clk;

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask

	// One result, then settle past the flag and touch update edges
	task automatic send(input logic [15:0] d);
		@(posedge core_clk);
		cdc_valid <= 1'b1;
		cdc_data <= d;
		@(posedge core_clk);
		cdc_valid <= 1'b0;
		cdc_data <= ~d;
		@(posedge core_clk);
		#1;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		host_i.rd(a, d);
		chk(d, exp, "read value");
	endtask

	task automatic t_reset;
		logic [7:0] a [7] = '{8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0D, 8'h2B};
		logic [7:0] e [7] = '{8'h00, 8'h02, 8'h50, 8'h33, 8'h08, 8'h00, 8'h4C};
		for (int i = 0; i < 7; i++) begin
			rdchk(a[i], e[i]);
		end
		rdchk(8'h03, 8'h00);
		rdchk(8'h2D, 8'h00);
		chk(run, 1'b1, "converter held after reset");
		chk(idle, 1'b0, "idle after reset");
	endtask

	task automatic t_config;
		logic [4:0] c [4] = '{5'h00, 5'h01, 5'h10, 5'h1F};
		for (int i = 0; i < 4; i++) begin
			host_i.wr(8'h07, {i[1:0], 1'b0, c[i]});
			// Outputs are flopped copies, one edge behind the register
			@(posedge core_clk);
			#1;
			chk(sel, i[1:0], "noise select");
			chk(comp, c[i], "compensation code");
			rdchk(8'h07, {i[1:0], 1'b0, c[i]});
		end
		host_i.wr(8'h0D, 8'h08);
		rdchk(8'h0D, 8'h08);
	endtask

	task automatic t_flag;
		logic [7:0] e [8] = '{8'h12, 8'h34, 8'h12, 8'h34, 8'h00, 8'h00, 8'h12, 8'h34};
		send(16'h1234);
		chk(irq_oe, 1'b1, "interrupt not driven");
		rdchk(8'h2D, 8'h01);
		#1;
		chk(irq_oe, 1'b0, "interrupt not released");
		rdchk(8'h2D, 8'h00);
		for (int i = 0; i < 8; i++) begin
			rdchk(8'h20 + i[7:0], e[i]);
		end
		host_i.wr(8'h0D, 8'h00);
		send(16'h1234);
		chk(irq_oe, 1'b0, "masked interrupt driven");
		rdchk(8'h2D, 8'h01);
	endtask

	task automatic t_track;
		host_i.wr(8'h0A, 8'h11);
		send(16'h1238);
		send(16'h1238);
		rdchk(8'h27, 8'h35);
		send(16'h1232);
		send(16'h1232);
		rdchk(8'h27, 8'h34);
	endtask

	// Thresholds near the deltas: on at 4 x 0x32, off below 4 x 0x01
	task automatic t_touch;
		on_lim <= 8'h32;
		off_lim <= 8'h01;
		host_i.wr_deb(2'b01);
		for (int i = 0; i < 3; i++) begin
			send(16'h1300);
			chk(touch, 1'b0, "touch too early");
		end
		send(16'h1300);
		chk(touch, 1'b1, "touch not on");
		send(16'h1230);
		chk(touch, 1'b1, "touch off too early");
		send(16'h1230);
		chk(touch, 1'b0, "touch not off");
	endtask

	// Smoothing starts from 0x1230 in bypass
	task automatic t_smooth;
		host_i.wr_coef(2'b10);
		send(16'h1340);
		rdchk(8'h22, 8'h12);
		rdchk(8'h23, 8'hB8);
		host_i.wr_coef(2'b00);
		send(16'h1340);
		rdchk(8'h20, 8'h13);
		rdchk(8'h23, 8'hDA);
	endtask

	task automatic print_verdict;
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge core_clk);
		sys_rst <= 1'b0;
		t_reset();
		t_config();
		t_flag();
		t_track();
		t_touch();
		t_smooth();
		print_verdict();
	end

	// Whole run needs well under a thousand cycles
	initial begin
		#100000;
		num_errors++;
		$display("[FAIL] %0t watchdog expired", $time);
		print_verdict();
	end
endmodule // tb_top
`default_nettype wire
